//--- mqf_flag_ctrl.sv
// Top of the multi-queue flag bus, full flag and programming method logic
`timescale 1ns/1ps
module mqf_flag_ctrl
    import mqf_pkg::*;
#(
    parameter int QUEUES = MQF_QUEUES,
    parameter logic [MQF_POS_W-1:0] FIRST_POS = 3'h0
)
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic master_reset,
    input wire logic config_method_select,
    input wire logic flag_bus_mode_select,
    input wire logic [MQF_POS_W-1:0] chain_position_code,
    input wire logic [MQF_RADDR_W-1:0] read_queue_addr,
    input wire logic [MQF_WADDR_W-1:0] write_queue_addr,
    input wire logic write_addr_enable,
    input wire logic empty_bus_strobe,
    input wire logic full_bus_strobe,
    input wire logic empty_token_in,
    input wire logic full_token_in,
    input wire logic [QUEUES-1:0] queue_almost_empty,
    input wire logic [QUEUES-1:0] queue_packet_ready,
    input wire logic [QUEUES-1:0] queue_almost_full,
    input wire logic [QUEUES-1:0] queue_full,
    output logic [QUEUES-1:0] almost_empty_bus,
    output logic almost_empty_bus_oe,
    output logic [QUEUES-1:0] almost_full_bus,
    output logic almost_full_bus_oe,
    output logic empty_bus_sync,
    output logic full_bus_sync,
    output logic empty_token_out,
    output logic full_token_out,
    output logic queue_full_n,
    output logic queue_full_n_oe,
    output logic serial_program_done_n,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [MQF_AV_ADDR_W-1:0] avs_address,
    input wire logic [MQF_AV_DATA_W-1:0] avs_writedata,
    output logic [MQF_AV_DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest
);
    import mqf_pkg::*;

    typedef enum logic [1:0]
    {
        MQF_PROG_IDLE,
        MQF_PROG_WAIT,
        MQF_PROG_DONE
    } mqf_prog_t;

    // ==========================================================
    // Straps caught while master reset is high
    mqf_straps_t straps_r;
    mqf_prog_t prog_r;
    logic active;
    logic first_r;
    logic start_r;

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            straps_r <= '{MQF_DIRECT, MQF_SERIAL, '0};
        end
        else if (master_reset)
        begin
            // Pins assumed stable in operation, so caught only here
            straps_r.mode <= mqf_flag_mode_t'(flag_bus_mode_select);
            straps_r.method <= mqf_method_t'(config_method_select);
            straps_r.pos <= chain_position_code;
        end
    end

    // ==========================================================
    // Programming method
    logic [MQF_AV_DATA_W-1:0] ctrl_r;

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            prog_r <= MQF_PROG_IDLE;
        end
        else if (master_reset)
        begin
            prog_r <= MQF_PROG_IDLE;
        end
        else
        begin
            unique case (prog_r)
                MQF_PROG_IDLE:
                begin
                    // Default method needs no serial load
                    prog_r <= (straps_r.method == MQF_DEFAULT) ? MQF_PROG_DONE
                                                               : MQF_PROG_WAIT;
                end
                MQF_PROG_WAIT:
                begin
                    if (ctrl_r[MQF_CTRL_PROG_DONE])
                    begin
                        prog_r <= MQF_PROG_DONE;
                    end
                end
                MQF_PROG_DONE:
                begin
                    prog_r <= MQF_PROG_DONE;
                end
            endcase
        end
    end

    assign active = (prog_r == MQF_PROG_DONE);

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            serial_program_done_n <= 1'b1;
        end
        else
        begin
            // Strobes are legal only once this is low
            serial_program_done_n <= !active;
        end
    end

    // One start pulse for the first device, so exactly one token circulates
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            first_r <= 1'b0;
            start_r <= 1'b0;
        end
        else if (master_reset)
        begin
            first_r <= 1'b0;
            start_r <= 1'b0;
        end
        else
        begin
            first_r <= active;
            start_r <= active && !first_r && (straps_r.mode == MQF_POLLED)
                       && mqf_hit(straps_r.pos, FIRST_POS);
        end
    end

    // ==========================================================
    // Empty and full flag busses
    mqf_bus_req_t ereq;
    mqf_bus_req_t freq;
    mqf_bus_out_t eout;
    mqf_bus_out_t fout;
    logic [QUEUES-1:0] empty_src;

    // Packet mode swaps in packet ready status on the empty bus
    assign empty_src = ctrl_r[MQF_CTRL_PACKET] ? queue_packet_ready : queue_almost_empty;

    assign ereq.strobe = empty_bus_strobe;
    assign ereq.addr_hit = mqf_hit(read_queue_addr[MQF_RADDR_W-1 -: MQF_POS_W],
                                   straps_r.pos);
    assign ereq.token_in = empty_token_in;

    assign freq.strobe = full_bus_strobe;
    assign freq.addr_hit = mqf_hit(write_queue_addr[MQF_WADDR_W-1 -: MQF_POS_W],
                                   straps_r.pos);
    assign freq.token_in = full_token_in;

    mqf_flag_slice #(.WIDTH(QUEUES)) u_empty
    (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .active(active && !master_reset),
        .mode(straps_r.mode),
        .start(start_r),
        .req(ereq),
        .flags(empty_src),
        .out(eout)
    );

    mqf_flag_slice #(.WIDTH(QUEUES)) u_full
    (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .active(active && !master_reset),
        .mode(straps_r.mode),
        .start(start_r),
        .req(freq),
        .flags(queue_almost_full),
        .out(fout)
    );

    assign almost_empty_bus = eout.bus;
    assign almost_empty_bus_oe = eout.bus_oe;
    assign empty_bus_sync = eout.sync;
    assign empty_token_out = eout.token_out;
    assign almost_full_bus = fout.bus;
    assign almost_full_bus_oe = fout.bus_oe;
    assign full_bus_sync = fout.sync;
    assign full_token_out = fout.token_out;

    // ==========================================================
    // Full flag of the active write queue
    logic [MQF_QSEL_W-1:0] wq_r;
    logic wsel_r;
    logic wsel_nxt;
    logic [MQF_QSEL_W-1:0] wq_nxt;

    always_comb
    begin
        wsel_nxt = wsel_r;
        wq_nxt = wq_r;
        if (write_addr_enable && active)
        begin
            wsel_nxt = freq.addr_hit;
            wq_nxt = write_queue_addr[MQF_QSEL_W-1:0];
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wsel_r <= 1'b0;
            wq_r <= '0;
            queue_full_n <= 1'b1;
            queue_full_n_oe <= 1'b0;
        end
        else if (master_reset)
        begin
            wsel_r <= 1'b0;
            queue_full_n <= 1'b1;
            queue_full_n_oe <= 1'b0;
        end
        else
        begin
            wsel_r <= wsel_nxt;
            wq_r <= wq_nxt;
            // Shows the new queue on the very cycle after selection
            queue_full_n <= !queue_full[wq_nxt];
            queue_full_n_oe <= wsel_nxt;
        end
    end

    // ==========================================================
    // Avalon-MM slave, one wait cycle per access
    mqf_av_req_t av;
    logic wait_r;
    logic take;

    assign av = '{avs_read, avs_write, avs_address, avs_writedata};
    assign take = (av.read || av.write) && wait_r;
    assign avs_waitrequest = wait_r;

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wait_r <= 1'b1;
        end
        else
        begin
            wait_r <= !take;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctrl_r <= '0;
        end
        else if (master_reset)
        begin
            ctrl_r <= '0;
        end
        else if (av.write && !wait_r && (av.address == MQF_REG_CTRL))
        begin
            // Write lands only on the edge that completes the transfer
            ctrl_r <= '0;
            ctrl_r[MQF_CTRL_PACKET:MQF_CTRL_PROG_DONE] <=
                av.writedata[MQF_CTRL_PACKET:MQF_CTRL_PROG_DONE];
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            avs_readdata <= '0;
        end
        else if (take && av.read)
        begin
            avs_readdata <= '0;
            unique case (av.address)
                MQF_REG_CTRL:
                begin
                    avs_readdata[MQF_CTRL_PACKET:MQF_CTRL_PROG_DONE] <=
                        ctrl_r[MQF_CTRL_PACKET:MQF_CTRL_PROG_DONE];
                end
                MQF_REG_STATUS:
                begin
                    avs_readdata[MQF_ST_POLLED] <= (straps_r.mode == MQF_POLLED);
                    avs_readdata[MQF_ST_DEFAULT] <= (straps_r.method == MQF_DEFAULT);
                    avs_readdata[MQF_ST_DONE_N] <= serial_program_done_n;
                    avs_readdata[MQF_ST_POS_LSB +: MQF_POS_W] <= straps_r.pos;
                end
                MQF_REG_SELECT:
                begin
                    avs_readdata[MQF_SEL_WQ_LSB +: MQF_QSEL_W] <= wq_r;
                    avs_readdata[MQF_SEL_WOWN] <= wsel_r;
                    avs_readdata[MQF_SEL_EOWN] <= eout.owned;
                    avs_readdata[MQF_SEL_FOWN] <= fout.owned;
                end
                default:
                begin
                    // Unmapped reads answer zero
                    avs_readdata <= '0;
                end
            endcase
        end
    end

endmodule

//--- mqf_pkg.sv
// Package with constants, types and the register map of the flag bus controller
package mqf_pkg;

    // ==========================================================
    // Widths
    localparam int MQF_QUEUES = 8;
    localparam int MQF_POS_W = 3;
    localparam int MQF_QSEL_W = 3;
    localparam int MQF_WADDR_W = 6;
    localparam int MQF_RADDR_W = 7;
    localparam int MQF_AV_ADDR_W = 4;
    localparam int MQF_AV_DATA_W = 32;

    // ==========================================================
    // Register map, byte addresses
    localparam logic [MQF_AV_ADDR_W-1:0] MQF_REG_CTRL = 4'h0;
    localparam logic [MQF_AV_ADDR_W-1:0] MQF_REG_STATUS = 4'h4;
    localparam logic [MQF_AV_ADDR_W-1:0] MQF_REG_SELECT = 4'h8;

    // CTRL fields
    localparam int MQF_CTRL_PROG_DONE = 0;
    localparam int MQF_CTRL_PACKET = 1;
    localparam logic [1:0] MQF_CTRL_RST = 2'h0;

    // STATUS fields
    localparam int MQF_ST_POLLED = 0;
    localparam int MQF_ST_DEFAULT = 1;
    localparam int MQF_ST_DONE_N = 2;
    localparam int MQF_ST_POS_LSB = 4;

    // SELECT fields
    localparam int MQF_SEL_WQ_LSB = 0;
    localparam int MQF_SEL_WOWN = 4;
    localparam int MQF_SEL_EOWN = 5;
    localparam int MQF_SEL_FOWN = 6;

    // ==========================================================
    // Types
    typedef enum logic
    {
        MQF_DIRECT,
        MQF_POLLED
    } mqf_flag_mode_t;

    typedef enum logic
    {
        MQF_SERIAL,
        MQF_DEFAULT
    } mqf_method_t;

    typedef struct packed
    {
        mqf_flag_mode_t mode;
        mqf_method_t method;
        logic [MQF_POS_W-1:0] pos;
    } mqf_straps_t;

    typedef struct packed
    {
        logic strobe;
        logic addr_hit;
        logic token_in;
    } mqf_bus_req_t;

    typedef struct packed
    {
        logic [MQF_QUEUES-1:0] bus;
        logic bus_oe;
        logic sync;
        logic token_out;
        logic owned;
    } mqf_bus_out_t;

    typedef struct packed
    {
        logic read;
        logic write;
        logic [MQF_AV_ADDR_W-1:0] address;
        logic [MQF_AV_DATA_W-1:0] writedata;
    } mqf_av_req_t;

    function automatic logic mqf_hit(input logic [MQF_POS_W-1:0] top,
                                     input logic [MQF_POS_W-1:0] pos);
        return top == pos;
    endfunction

endpackage

//--- mqf_flag_slice.sv
// One flag bus port: direct strobe selection or polled token passing
`timescale 1ns/1ps
module mqf_flag_slice
    import mqf_pkg::*;
#(
    parameter int WIDTH = MQF_QUEUES
)
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic active,
    input wire mqf_pkg::mqf_flag_mode_t mode,
    input wire logic start,
    input wire mqf_pkg::mqf_bus_req_t req,
    input wire logic [WIDTH-1:0] flags,
    output mqf_pkg::mqf_bus_out_t out
);
    // ==========================================================
    // Ownership and bus drive
    logic own_r;
    logic own_nxt;
    logic turn;

    // Token arrival, or the one start pulse of the first device, gives our turn
    assign turn = active && (mode == MQF_POLLED) && (req.token_in || start);

    always_comb
    begin
        own_nxt = own_r;
        if (!active)
        begin
            own_nxt = 1'b0;
        end
        else if (mode == MQF_DIRECT)
        begin
            if (req.strobe)
            begin
                own_nxt = req.addr_hit;
            end
        end
        else
        begin
            own_nxt = turn;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            own_r <= 1'b0;
        end
        else
        begin
            own_r <= own_nxt;
        end
    end

    // Bus, sync and token all come from flops; in polled mode they move together
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            out <= '0;
        end
        else
        begin
            out.owned <= own_nxt;
            out.bus_oe <= own_nxt;
            out.bus <= own_nxt ? flags : '0;
            out.sync <= turn;
            out.token_out <= turn;
        end
    end

endmodule

//--- mqf_flag_ctrl_assertions.sv
// Checker of the flag bus controller, top ports only
`timescale 1ns/1ps
module mqf_flag_ctrl_assertions
    import mqf_pkg::*;
#(
    parameter int QUEUES = MQF_QUEUES
)
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic master_reset,
    input wire logic config_method_select,
    input wire logic flag_bus_mode_select,
    input wire logic [MQF_POS_W-1:0] chain_position_code,
    input wire logic [MQF_RADDR_W-1:0] read_queue_addr,
    input wire logic [MQF_WADDR_W-1:0] write_queue_addr,
    input wire logic write_addr_enable,
    input wire logic empty_bus_strobe,
    input wire logic full_bus_strobe,
    input wire logic empty_token_in,
    input wire logic full_token_in,
    input wire logic [QUEUES-1:0] queue_full,
    input wire logic almost_empty_bus_oe,
    input wire logic almost_full_bus_oe,
    input wire logic empty_bus_sync,
    input wire logic full_bus_sync,
    input wire logic empty_token_out,
    input wire logic full_token_out,
    input wire logic queue_full_n,
    input wire logic queue_full_n_oe,
    input wire logic serial_program_done_n
);
    import mqf_pkg::*;
    // ==========================================================
    // Helpers
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    logic ok;
    logic hit_e;
    logic hit_w;
    logic fexp_r;
    assign ok = !master_reset && !serial_program_done_n;
    assign hit_e = read_queue_addr[6:4] == chain_position_code;
    assign hit_w = write_queue_addr[5:3] == chain_position_code;
    // Inverted full value of the queue addressed at each edge
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            fexp_r <= 1'b1;
        else
            fexp_r <= !queue_full[write_queue_addr[2:0]];
    end
    // ==========================================================
    // Properties
    property p_serial;
        $fell(master_reset) && !config_method_select |-> serial_program_done_n [*3];
    endproperty
    a_serial: assert property (p_serial)
        else $error("programming done too early");
    property p_default;
        $fell(master_reset) && config_method_select |-> ##[1:6] !serial_program_done_n;
    endproperty
    a_default: assert property (p_default)
        else $error("default programming never done");
    property p_dir_e;
        empty_bus_strobe && ok && !flag_bus_mode_select |=> almost_empty_bus_oe == $past(hit_e);
    endproperty
    a_dir_e: assert property (p_dir_e)
        else $error("empty bus ownership wrong");
    property p_dir_f;
        full_bus_strobe && ok && !flag_bus_mode_select |=> almost_full_bus_oe == $past(hit_w);
    endproperty
    a_dir_f: assert property (p_dir_f)
        else $error("full bus ownership wrong");
    property p_ff_oe;
        write_addr_enable && ok |=> queue_full_n_oe == $past(hit_w);
    endproperty
    a_ff_oe: assert property (p_ff_oe)
        else $error("full flag drive wrong");
    property p_ff_val;
        write_addr_enable && ok && hit_w |=> queue_full_n == fexp_r;
    endproperty
    a_ff_val: assert property (p_ff_val)
        else $error("full flag value wrong");
    property p_etok;
        empty_token_in && ok && flag_bus_mode_select |=> empty_bus_sync && empty_token_out;
    endproperty
    a_etok: assert property (p_etok)
        else $error("empty token not taken");
    property p_empty_bus_sync;
        empty_bus_sync |-> empty_token_out && almost_empty_bus_oe;
    endproperty
    a_empty_bus_sync: assert property (p_empty_bus_sync)
        else $error("empty sync without bus");
    property p_ftok;
        full_token_in && ok && flag_bus_mode_select |=> full_bus_sync && full_token_out;
    endproperty
    a_ftok: assert property (p_ftok)
        else $error("full token not taken");
    property p_full_bus_sync;
        full_bus_sync |-> full_token_out && almost_full_bus_oe;
    endproperty
    a_full_bus_sync: assert property (p_full_bus_sync)
        else $error("full sync without bus");
    c_dir: cover property (empty_bus_strobe && ok && hit_e);
    c_poll: cover property (empty_bus_sync && full_bus_sync);
    c_ff: cover property (queue_full_n_oe && !queue_full_n);
endmodule

//--- mqf_chain_model.sv
// Model of the other chained devices passing the polling token
`timescale 1ns/1ps
module mqf_chain_model
#(
    parameter int OTHERS = 2
)
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic direct,
    input wire logic tok_out,
    output logic tok_in
);
    // ==========================================================
    // Each other device shows its flags for one clock
    logic [OTHERS-1:0] hold_r;
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            hold_r <= '0;
        else
            hold_r <= {hold_r[OTHERS-2:0], tok_out};
    end
    // Direct mode ties input low; polled loops last device back
    assign tok_in = direct ? 1'b0 : hold_r[OTHERS-1];
endmodule

//--- mqf_flag_ctrl_test.sv
// Self-checking bench of the flag bus controller
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module mqf_flag_ctrl_test;
    import mqf_pkg::*;
    localparam logic [2:0] POS = 3'h2;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic master_reset = 1'b1;
    logic config_method_select = 1'b0;
    logic flag_bus_mode_select = 1'b0;
    logic [2:0] chain_position_code = POS;
    logic [6:0] read_queue_addr = '0;
    logic [5:0] write_queue_addr = '0;
    logic write_addr_enable = 1'b0;
    logic empty_bus_strobe = 1'b0;
    logic full_bus_strobe = 1'b0;
    logic [7:0] queue_almost_empty = 8'h5a;
    logic [7:0] queue_packet_ready = 8'hc3;
    logic [7:0] queue_almost_full = 8'h3c;
    logic [7:0] queue_full = 8'h81;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [3:0] avs_address = '0;
    logic [31:0] avs_writedata = '0;
    logic [7:0] almost_empty_bus, almost_full_bus;
    logic [31:0] avs_readdata, rd;
    logic empty_token_in, full_token_in, almost_empty_bus_oe, almost_full_bus_oe;
    logic empty_bus_sync, full_bus_sync, empty_token_out, full_token_out;
    logic queue_full_n, queue_full_n_oe, serial_program_done_n, avs_waitrequest;
    int err_total = 0;
    int tests_run = 0;
    int cyc = 0;
    // ==========================================================
    // Clock, design, far side
    always #12.5 mclk = !mclk;
    mqf_flag_ctrl #(.FIRST_POS(POS)) uut (.mclk, .sys_rst, .master_reset,
        .config_method_select, .flag_bus_mode_select, .chain_position_code,
        .read_queue_addr, .write_queue_addr, .write_addr_enable, .empty_bus_strobe,
        .full_bus_strobe, .empty_token_in, .full_token_in, .queue_almost_empty,
        .queue_packet_ready, .queue_almost_full, .queue_full, .almost_empty_bus,
        .almost_empty_bus_oe, .almost_full_bus, .almost_full_bus_oe, .empty_bus_sync,
        .full_bus_sync, .empty_token_out, .full_token_out, .queue_full_n,
        .queue_full_n_oe, .serial_program_done_n, .avs_read, .avs_write, .avs_address,
        .avs_writedata, .avs_readdata, .avs_waitrequest);
    mqf_chain_model #(.OTHERS(2)) u_echain (.mclk, .sys_rst,
        .direct(!flag_bus_mode_select), .tok_out(empty_token_out), .tok_in(empty_token_in));
    mqf_chain_model #(.OTHERS(2)) u_fchain (.mclk, .sys_rst,
        .direct(!flag_bus_mode_select), .tok_out(full_token_out), .tok_in(full_token_in));
    // ==========================================================
    // Tasks
    task test_done;
        $display("Checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task mrst(input logic m, input logic s);
        @(posedge mclk);
        master_reset <= 1'b1;
        flag_bus_mode_select <= m;
        config_method_select <= s;
        repeat (2) @(posedge mclk);
        master_reset <= 1'b0;
    endtask
    // Holds the request until waitrequest is seen low
    task av(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        avs_write <= wr;
        avs_read <= !wr;
        avs_address <= a;
        avs_writedata <= d;
        // Only the watchdog ends a hung wait
        do
        begin
            @(posedge mclk);
        end
        while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task t_serial;
        mrst(1'b0, 1'b0);
        repeat (6) @(posedge mclk);
        `CHK(serial_program_done_n, 1'b1)
        av(1'b0, MQF_REG_STATUS, '0);
        `CHK(rd, 32'h24)
        av(1'b0, 4'hc, '0);
        `CHK(rd, 32'h0)
        av(1'b1, MQF_REG_CTRL, 32'h1);
        repeat (3) @(posedge mclk);
        `CHK(serial_program_done_n, 1'b0)
    endtask
    task t_strobe(input logic hit, input logic [7:0] ee);
        `CHK(serial_program_done_n, 1'b0)
        @(posedge mclk);
        empty_bus_strobe <= 1'b1;
        full_bus_strobe <= 1'b1;
        read_queue_addr <= {hit ? POS : ~POS, 4'h1};
        write_queue_addr <= {hit ? POS : ~POS, 3'h1};
        @(posedge mclk);
        empty_bus_strobe <= 1'b0;
        full_bus_strobe <= 1'b0;
        @(posedge mclk);
        `CHK(almost_empty_bus_oe, hit)
        `CHK(almost_empty_bus, ee)
        `CHK(almost_full_bus_oe, hit)
        `CHK(almost_full_bus, hit ? queue_almost_full : 8'h0)
    endtask
    task t_full(input logic [5:0] a, input logic oe, input logic v);
        @(posedge mclk);
        write_addr_enable <= 1'b1;
        write_queue_addr <= a;
        @(posedge mclk);
        write_addr_enable <= 1'b0;
        @(posedge mclk);
        `CHK(queue_full_n_oe, oe)
        if (oe)
            `CHK(queue_full_n, v)
        av(1'b0, MQF_REG_SELECT, '0);
        `CHK(rd, {27'h0, oe, 1'b0, a[2:0]})
    endtask
    // Three devices in the loop: each sync once every third clock
    task t_polled;
        int ne;
        int nf;
        ne = 0;
        nf = 0;
        mrst(1'b1, 1'b1);
        empty_bus_strobe <= 1'b0;
        full_bus_strobe <= 1'b0;
        repeat (10) @(posedge mclk);
        repeat (12)
        begin
            @(posedge mclk);
            ne += empty_bus_sync;
            nf += full_bus_sync;
            `CHK(empty_token_out, empty_bus_sync)
            `CHK(full_token_out, full_bus_sync)
            if (empty_bus_sync)
                `CHK(almost_empty_bus, queue_almost_empty)
            if (full_bus_sync)
                `CHK(almost_full_bus, queue_almost_full)
        end
        `CHK(ne, 4)
        `CHK(nf, 4)
        av(1'b0, MQF_REG_STATUS, '0);
        `CHK(rd, 32'h23)
    endtask
    // ==========================================================
    // Sequence and watchdog
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_total++;
            test_done;
        end
    end
    initial
    begin
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        t_serial;
        t_strobe(1'b1, queue_almost_empty);
        t_strobe(1'b0, 8'h0);
        t_full({POS, 3'h7}, 1'b1, 1'b0);
        t_full({POS, 3'h3}, 1'b1, 1'b1);
        t_full({~POS, 3'h0}, 1'b0, 1'b1);
        av(1'b1, MQF_REG_CTRL, 32'h3);
        t_strobe(1'b1, queue_packet_ready);
        t_polled;
        test_done;
    end
endmodule
bind mqf_flag_ctrl mqf_flag_ctrl_assertions #(.QUEUES(QUEUES)) u_chk (.mclk, .sys_rst,
    .master_reset, .config_method_select, .flag_bus_mode_select, .chain_position_code,
    .read_queue_addr, .write_queue_addr, .write_addr_enable, .empty_bus_strobe,
    .full_bus_strobe, .empty_token_in, .full_token_in, .queue_full, .almost_empty_bus_oe,
    .almost_full_bus_oe, .empty_bus_sync, .full_bus_sync, .empty_token_out,
    .full_token_out, .queue_full_n, .queue_full_n_oe, .serial_program_done_n);
